/* lsp_defines.vh */
`ifndef LSP_DEFINES_VH
`define LSP_DEFINES_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LSP_OFS_CTRL 5'h00
`define LSP_OFS_CWORD 5'h04
`define LSP_OFS_DIST 5'h08
`define LSP_OFS_RATED 5'h0C
`define LSP_OFS_RAMP 5'h10
`define LSP_OFS_STATUS 5'h14
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define LSP_CTRL_SLOW_RISE 0
`define LSP_CTRL_STOP_RISE 1
`define LSP_CTRL_SLOW_MODE_LO 2
`define LSP_CTRL_SLOW_MODE_HI 3
`define LSP_CTRL_STOP_MODE_LO 4
`define LSP_CTRL_STOP_MODE_HI 5
`define LSP_CTRL_SRC_CWORD 6
`define LSP_CTRL_DIS_CWORD 7
`define LSP_CTRL_SAD_EN 8
`define LSP_CTRL_DECEL_PROF 9
`define LSP_CTRL_LONG_CAM 10
`define LSP_CTRL_FACTORY 11
`define LSP_CTRL_W 11
`define LSP_CTRL_RST 11'h002
// ----------------------------------------------------------------
// control word bits and channel order
// ----------------------------------------------------------------
`define LSP_CH_SLOW_FWD 0
`define LSP_CH_SLOW_REV 1
`define LSP_CH_STOP_FWD 2
`define LSP_CH_STOP_REV 3
`define LSP_CW_DISABLE 4
`define LSP_CW_W 5
`define LSP_CW_RST 5'h00
// ----------------------------------------------------------------
// data widths, reset values and timing
// ----------------------------------------------------------------
`define LSP_VAL_W 16
`define LSP_ACC_W 32
`define LSP_VAL_RST 16'h0000
`define LSP_ACC_RST 32'h0000_0000
`define LSP_RD_ZERO 32'h0000_0000
`define LSP_TICK_NS 1000
`define LSP_CLK_NS 4
`define LSP_TICK_CYC (`LSP_TICK_NS / `LSP_CLK_NS)
`define LSP_TICK_W 8
`define LSP_TICK_LAST 8'hF9
`define LSP_SPEED_SHIFT 16
`endif

/* lsp_positioning.v */
// How it works
// - active edge selectable, rising or falling
// - separate slowdown mode and stop mode selections
// - same logic both directions, stop as slowdown
// - forward slowdown latches on edge while forward
// - latched state kept in non-volatile storage
// - reverse travel stays full speed while latched
// - clear on inactive edge while running reverse
// - disable from logic input or control word
// - disable hides slowdown, latches keep tracking
// - long cams: initialise anywhere on travel
// - stop at distance from speed and rating
// - stop switch beats stop at distance
// - decel profile selects distance behaviour
// - ramp change drops the distance target
// - direction change drops the distance target
// - distance stop never resumed after power-up
// - stop polarity setting, rising by default
`timescale 1ns/1ps
`default_nettype none
`include "lsp_defines.vh"
module lsp_positioning
(
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // avalon-mm slave
  input wire [4:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  // sensor and disable pins, asynchronous
  input wire fwd_slow_pin_in,
  input wire rev_slow_pin_in,
  input wire fwd_stop_pin_in,
  input wire rev_stop_pin_in,
  input wire disable_pin_in,
  // motor state from drive control, same clock
  input wire run_fwd_in,
  input wire run_rev_in,
  input wire [15:0] speed_est_in,
  // non-volatile latch storage
  input wire [3:0] nv_latch_in,
  output reg [3:0] nv_latch_out,
  output reg nv_write_out,
  // actions toward the speed loop
  output reg slow_fwd_out,
  output reg slow_rev_out,
  output reg stop_out,
  output reg [1:0] slow_mode_out,
  output reg [1:0] stop_mode_out,
  output reg sad_active_out
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // byte-lane merge used by every writable register
  function [31:0] lsp_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] be;
    integer k;
    begin
      lsp_merge = old_val;
      for (k = 0; k < 4; k = k + 1)
      begin
        if (be[k])
          lsp_merge[k*8 +: 8] = new_val[k*8 +: 8];
      end
    end
  endfunction

  // edge toward the active level for the chosen polarity
  function lsp_active_edge;
    input cur;
    input prev;
    input rise;
    begin
      lsp_active_edge = rise ? (cur & ~prev) : (~cur & prev);
    end
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg [`LSP_CTRL_W-1:0] ctrl_ff; // configuration
  reg [`LSP_CW_W-1:0] cword_ff; // control word bits
  reg [`LSP_VAL_W-1:0] dist_ff; // target distance
  reg [`LSP_VAL_W-1:0] rated_ff; // rated linear speed
  reg [`LSP_VAL_W-1:0] ramp_ff; // deceleration ramp setting
  reg ramp_chg_ff; // ramp written with a new value
  reg factory_ff; // one-cycle factory restore pulse
  wire bus_req = avs_read_in | avs_write_in;
  wire bus_go = bus_req & ~avs_waitrequest_out;
  wire wr_go = avs_write_in & bus_go;

  // ----------------------------------------------------------------
  // input synchronisers and sources
  // ----------------------------------------------------------------
  wire [4:0] pin_raw = {disable_pin_in, rev_stop_pin_in, fwd_stop_pin_in,
                        rev_slow_pin_in, fwd_slow_pin_in};
  reg [4:0] meta_ff; // first stage, read only by sync_ff
  reg [4:0] sync_ff; // second stage
  reg [3:0] prev_ff; // previous sample of each channel
  reg [3:0] latch_ff; // latched slowdown and stop requests
  reg restore_ff; // high for the cycle after reset release
  reg init_ff; // long-cam initialisation done
  wire [3:0] chan_cur;
  wire [3:0] act_edge;
  wire [3:0] inact_edge;
  wire [3:0] ch_run;
  wire [3:0] ch_opp;
  wire dis_cur;

  // no reset: the samples follow the pins through reset, so a pin held high
  // is not taken as a fresh edge after release; power-up reset needs 3 edges
  always @(posedge clk_in)
  begin
    meta_ff <= pin_raw;
    sync_ff <= meta_ff;
    prev_ff <= chan_cur;
  end

  // source select: pins or control word bits
  assign chan_cur = ctrl_ff[`LSP_CTRL_SRC_CWORD] ? cword_ff[3:0] : sync_ff[3:0];
  // disable may be assigned to a pin or to a control word bit
  assign dis_cur = ctrl_ff[`LSP_CTRL_DIS_CWORD] ? cword_ff[`LSP_CW_DISABLE]
                                                : sync_ff[4];

  // ----------------------------------------------------------------
  // per-channel edge detect and direction qualify
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gen_ch
      // channels 0 and 1 use slowdown polarity, 2 and 3 stop polarity
      wire rise = (g < 2) ? ctrl_ff[`LSP_CTRL_SLOW_RISE]
                          : ctrl_ff[`LSP_CTRL_STOP_RISE];
      assign act_edge[g] = lsp_active_edge(chan_cur[g], prev_ff[g], rise);
      assign inact_edge[g] = lsp_active_edge(chan_cur[g], prev_ff[g], ~rise);
      // even channels face forward, odd ones reverse
      assign ch_run[g] = (g % 2 == 0) ? run_fwd_in : run_rev_in;
      assign ch_opp[g] = (g % 2 == 0) ? run_rev_in : run_fwd_in;
    end
  endgenerate

  // active level, used by the long-cam start-up
  wire [3:0] act_level = {{2{ctrl_ff[`LSP_CTRL_STOP_RISE]}},
                          {2{ctrl_ff[`LSP_CTRL_SLOW_RISE]}}} ~^ chan_cur;
  wire running = run_fwd_in | run_rev_in;

  // ----------------------------------------------------------------
  // latch update
  // ----------------------------------------------------------------
  reg [3:0] nxt_latch;
  always @*
  begin
    nxt_latch = latch_ff;
    if (restore_ff)
      nxt_latch = nv_latch_in;
    else if (factory_ff)
      nxt_latch = 4'h0;
    else if (ctrl_ff[`LSP_CTRL_LONG_CAM] && !init_ff && running)
      // long cam covers the zone end to end, so level tells position
      nxt_latch = act_level & ch_run;
    else
      // disable is not consulted here: tracking continues
      nxt_latch = (latch_ff | (act_edge & ch_run))
                  & ~(inact_edge & ch_opp);
  end

  // latch, restore and init flags and non-volatile write strobe
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      latch_ff <= 4'h0;
      restore_ff <= 1'b1;
      init_ff <= 1'b0;
      nv_latch_out <= 4'h0;
      nv_write_out <= 1'b0;
    end
    else
    begin
      latch_ff <= nxt_latch;
      restore_ff <= 1'b0;
      if (factory_ff)
        init_ff <= 1'b0; // short cams: start outside zones
      else if (running && !restore_ff)
        init_ff <= 1'b1;
      nv_latch_out <= nxt_latch;
      // store every change so a supply loss keeps the state
      nv_write_out <= ~restore_ff & (nxt_latch != latch_ff);
    end
  end

  // ----------------------------------------------------------------
  // stop at distance
  // ----------------------------------------------------------------
  reg sad_ff; // distance stop in progress
  reg sad_dir_ff; // direction at trip, 1 = forward
  reg sad_done_ff; // distance reached, stop asserted
  reg [`LSP_ACC_W-1:0] trav_ff; // travelled distance
  reg [`LSP_ACC_W-1:0] goal_ff; // distance at which to stop
  reg [`LSP_TICK_W-1:0] tick_ff; // integration prescaler
  wire tick = (tick_ff == `LSP_TICK_LAST);
  wire slow_trip = (act_edge[`LSP_CH_SLOW_FWD] & run_fwd_in)
                 | (act_edge[`LSP_CH_SLOW_REV] & run_rev_in);
  wire stop_sw = (latch_ff[`LSP_CH_STOP_FWD] & run_fwd_in)
               | (latch_ff[`LSP_CH_STOP_REV] & run_rev_in);
  wire dir_chg = sad_dir_ff ? run_rev_in : run_fwd_in;
  // travel per tick: estimated speed scaled by the rated linear speed
  wire [`LSP_ACC_W-1:0] step = (speed_est_in * rated_ff) >> `LSP_SPEED_SHIFT;
  // profile 1 reserves a braking allowance equal to the trip speed
  wire [`LSP_ACC_W-1:0] lead = ctrl_ff[`LSP_CTRL_DECEL_PROF]
                               ? {16'h0000, speed_est_in} : `LSP_ACC_RST;
  wire [`LSP_ACC_W-1:0] full = {16'h0000, dist_ff};

  // one process owns the whole distance sequence
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      // nothing of an interrupted distance stop survives reset
      sad_ff <= 1'b0;
      sad_dir_ff <= 1'b0;
      sad_done_ff <= 1'b0;
      trav_ff <= `LSP_ACC_RST;
      goal_ff <= `LSP_ACC_RST;
      tick_ff <= {`LSP_TICK_W{1'b0}};
    end
    else
    begin
      tick_ff <= tick ? {`LSP_TICK_W{1'b0}} : tick_ff + 1'b1;
      if (stop_sw || !running)
      begin
        // stop switch wins and ends any distance stop
        sad_ff <= 1'b0;
        sad_done_ff <= 1'b0;
      end
      else if (sad_ff && (ramp_chg_ff || dir_chg))
        sad_ff <= 1'b0;
      else if (!sad_ff && !sad_done_ff && slow_trip
               && ctrl_ff[`LSP_CTRL_SAD_EN] && !dis_cur)
      begin
        sad_ff <= 1'b1;
        sad_dir_ff <= run_fwd_in;
        trav_ff <= `LSP_ACC_RST;
        goal_ff <= (full > lead) ? full - lead : `LSP_ACC_RST;
      end
      else if (sad_ff)
      begin
        if (trav_ff >= goal_ff)
        begin
          sad_ff <= 1'b0;
          sad_done_ff <= 1'b1;
        end
        else if (tick)
          trav_ff <= trav_ff + step;
      end
    end
  end

  // ----------------------------------------------------------------
  // action outputs
  // ----------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      slow_fwd_out <= 1'b0;
      slow_rev_out <= 1'b0;
      stop_out <= 1'b0;
      slow_mode_out <= 2'b00;
      stop_mode_out <= 2'b00;
      sad_active_out <= 1'b0;
    end
    else
    begin
      // slowdown only toward the latched side; reverse stays fast
      slow_fwd_out <= latch_ff[`LSP_CH_SLOW_FWD] & run_fwd_in & ~dis_cur;
      slow_rev_out <= latch_ff[`LSP_CH_SLOW_REV] & run_rev_in & ~dis_cur;
      stop_out <= stop_sw | sad_done_ff;
      slow_mode_out <= ctrl_ff[`LSP_CTRL_SLOW_MODE_HI:`LSP_CTRL_SLOW_MODE_LO];
      stop_mode_out <= ctrl_ff[`LSP_CTRL_STOP_MODE_HI:`LSP_CTRL_STOP_MODE_LO];
      sad_active_out <= sad_ff;
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm register access
  // ----------------------------------------------------------------
  reg [31:0] rd_mux;
  reg [31:0] wr_val;
  always @*
  begin
    case (avs_address_in)
      `LSP_OFS_CTRL: rd_mux = {21'h00_0000, ctrl_ff};
      `LSP_OFS_CWORD: rd_mux = {27'h000_0000, cword_ff};
      `LSP_OFS_DIST: rd_mux = {16'h0000, dist_ff};
      `LSP_OFS_RATED: rd_mux = {16'h0000, rated_ff};
      `LSP_OFS_RAMP: rd_mux = {16'h0000, ramp_ff};
      `LSP_OFS_STATUS: rd_mux = {24'h00_0000, sad_done_ff, sad_ff, init_ff,
                                 dis_cur, latch_ff};
      default: rd_mux = `LSP_RD_ZERO; // unmapped reads as zero
    endcase
    wr_val = lsp_merge(rd_mux, avs_writedata_in, avs_byteenable_in);
  end

  // one wait state: the answer comes on the second edge of a request
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= `LSP_RD_ZERO;
      ctrl_ff <= `LSP_CTRL_RST;
      cword_ff <= `LSP_CW_RST;
      dist_ff <= `LSP_VAL_RST;
      rated_ff <= `LSP_VAL_RST;
      ramp_ff <= `LSP_VAL_RST;
      ramp_chg_ff <= 1'b0;
      factory_ff <= 1'b0;
    end
    else
    begin
      avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
      if (bus_req && avs_waitrequest_out)
        avs_readdata_out <= rd_mux;
      ramp_chg_ff <= 1'b0;
      factory_ff <= 1'b0;
      if (wr_go)
      begin
        case (avs_address_in)
          `LSP_OFS_CTRL:
          begin
            // factory bit is a self-clearing command, never stored
            ctrl_ff <= wr_val[`LSP_CTRL_W-1:0];
            factory_ff <= wr_val[`LSP_CTRL_FACTORY];
          end
          `LSP_OFS_CWORD: cword_ff <= wr_val[`LSP_CW_W-1:0];
          `LSP_OFS_DIST: dist_ff <= wr_val[`LSP_VAL_W-1:0];
          `LSP_OFS_RATED: rated_ff <= wr_val[`LSP_VAL_W-1:0];
          `LSP_OFS_RAMP:
          begin
            ramp_ff <= wr_val[`LSP_VAL_W-1:0];
            ramp_chg_ff <= (wr_val[`LSP_VAL_W-1:0] != ramp_ff);
          end
          default: ramp_chg_ff <= 1'b0; // status and unmapped ignore writes
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* lsp_positioning_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module lsp_positioning_props
(
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // register bus
  input wire [4:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  input wire avs_waitrequest_out,
  // motor and disable
  input wire disable_pin_in,
  input wire run_fwd_in,
  input wire run_rev_in,
  // latch store and actions
  input wire [3:0] nv_latch_out,
  input wire nv_write_out,
  input wire slow_fwd_out,
  input wire slow_rev_out,
  input wire [1:0] slow_mode_out,
  input wire [1:0] stop_mode_out
);
  // ------------------------------------------------
  // helper: mode fields of the last control write
  // ------------------------------------------------
  logic acc_ctrl; // control write accepted at this edge
  logic [3:0] wr_mode_ff; // stop and slow mode as written
  assign acc_ctrl = avs_write_in && !avs_waitrequest_out && avs_address_in == 5'h00 &&
    avs_byteenable_in[0];
  // capture only on acceptance, so a held request is not counted twice
  always @(posedge clk_in)
  begin
    if (acc_ctrl)
      wr_mode_ff <= avs_writedata_in[5:2];
  end
  default clocking dcb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_WAIT_ONE: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("no answer one cycle after request");
  AST_WAIT_PULSE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  AST_WAIT_IDLE: assert property (!avs_read_in && !avs_write_in |=> avs_waitrequest_out)
    else $error("answer without request");
  AST_MODE_COPY: assert property ($past(acc_ctrl, 2) |->
    {stop_mode_out, slow_mode_out} == wr_mode_ff) else $error("mode outputs not updated");
  AST_NV_HOLD: assert property (!$past(rst_in) && !$past(rst_in, 2) && !nv_write_out
    |-> $stable(nv_latch_out)) else $error("latch changed without store pulse");
  AST_SLOW_FWD: assert property (slow_fwd_out |-> $past(run_fwd_in))
    else $error("forward slowdown outside forward run");
  AST_SLOW_REV: assert property (slow_rev_out |-> $past(run_rev_in))
    else $error("reverse slowdown outside reverse run");
  AST_DIS_HIDE: assert property (disable_pin_in [*4] |->
    !slow_fwd_out && !slow_rev_out) else $error("slowdown shown while disabled");
endmodule
bind lsp_positioning lsp_positioning_props chk_u (.clk_in(clk_in), .rst_in(rst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_waitrequest_out(avs_waitrequest_out),
  .disable_pin_in(disable_pin_in), .run_fwd_in(run_fwd_in), .run_rev_in(run_rev_in),
  .nv_latch_out(nv_latch_out), .nv_write_out(nv_write_out),
  .slow_fwd_out(slow_fwd_out), .slow_rev_out(slow_rev_out),
  .slow_mode_out(slow_mode_out), .stop_mode_out(stop_mode_out));
`default_nettype wire

/* lsp_field_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lsp_field_model
(
  // clock
  input wire logic clk_in,
  // latch storage toward the block
  input wire logic nv_write_in,
  input wire logic [3:0] nv_data_in,
  output logic [3:0] nv_q_out,
  // sensor levels asked for by the bench
  input wire logic [4:0] level_in,
  output logic [4:0] pin_out
);
  // no reset here: the content must outlive a supply loss
  logic [3:0] store_ff = 4'h0;
  always @(posedge clk_in)
  begin
    if (nv_write_in)
      store_ff <= nv_data_in;
  end
  assign nv_q_out = store_ff;
  // contacts move between clock edges, not on them
  assign #1 pin_out = level_in;
endmodule
`default_nettype wire

/* limit_switch_positioning_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD t=%0t got %0h exp %0h", $time, a, b); end end
module limit_switch_positioning_tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, dv, e;
  logic waitreq, nv_w, slow_f, slow_r, stop, sad;
  logic [4:0] level = 5'h00; // {disable, rev stop, fwd stop, rev slow, fwd slow}
  logic [4:0] pins;
  logic run_fwd = 1'b0;
  logic run_rev = 1'b0;
  logic [15:0] speed = 16'h0000;
  logic [3:0] nv_q, nv_d, en;
  logic [1:0] smode, tmode;
  logic [31:0] seed = 32'he513;
  logic [31:0] rq[$]; // expected read data
  logic [3:0] nq[$]; // expected stored latch values
  int n_errors = 0;
  int total_checks = 0;
  lsp_positioning dut_u (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .fwd_slow_pin_in(pins[0]), .rev_slow_pin_in(pins[1]), .fwd_stop_pin_in(pins[2]),
    .rev_stop_pin_in(pins[3]), .disable_pin_in(pins[4]), .run_fwd_in(run_fwd),
    .run_rev_in(run_rev), .speed_est_in(speed), .nv_latch_in(nv_q), .nv_latch_out(nv_d),
    .nv_write_out(nv_w), .slow_fwd_out(slow_f), .slow_rev_out(slow_r), .stop_out(stop),
    .slow_mode_out(smode), .stop_mode_out(tmode), .sad_active_out(sad));
  lsp_field_model field_u (.clk_in(clk_in), .nv_write_in(nv_w), .nv_data_in(nv_d),
    .nv_q_out(nv_q), .level_in(level), .pin_out(pins));
  initial
  begin
    forever #2 clk_in = ~clk_in;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // the estimated speed wanders every cycle
  always @(posedge clk_in)
  begin
    seed <= xs(seed);
    speed <= seed[15:0];
  end
  task automatic end_of_test();
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    i = 0;
    do
    begin
      @(posedge clk_in);
      i++;
    end
    while (waitreq !== 1'b0 && i < 20);
    if (waitreq !== 1'b0)
    begin
      n_errors++;
      end_of_test();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] x);
    rq.push_back(x);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic set(input int i, input logic v);
    @(posedge clk_in);
    level[i] <= v;
  endtask
  task automatic go(input logic f, input logic r);
    @(posedge clk_in);
    run_fwd <= f;
    run_rev <= r;
  endtask
  // watcher: read data and store pulses against the oldest notes
  always @(posedge clk_in)
  begin
    if (rd && waitreq === 1'b0)
    begin
      e = (rq.size() > 0) ? rq.pop_front() : 32'hDEAD_BEEF;
      `CHK(rdata, e)
    end
    if (nv_w === 1'b1)
    begin
      en = (nq.size() > 0) ? nq.pop_front() : 4'hx;
      `CHK(nv_d, en)
    end
  end
  initial
  begin
    cyc(3);
    rst_in <= 1'b0;
    rdc(5'h00, 32'h0000_0002);
    rdc(5'h18, 32'h0000_0000);
    bus(1'b1, 5'h00, 32'h0000_0027);
    cyc(3);
    `CHK(smode, 2'h1)
    `CHK(tmode, 2'h2)
    // nonzero distance, so the later distance stop cannot end at once
    dv = seed | 32'h0000_0001;
    bus(1'b1, 5'h08, dv);
    rdc(5'h08, {16'h0000, dv[15:0]});
    // started outside every zone
    go(1'b1, 1'b0);
    nq.push_back(4'h1);
    set(0, 1'b1);
    cyc(6);
    `CHK(slow_f, 1'b1)
    set(0, 1'b0);
    cyc(6);
    `CHK(nv_d, 4'h1)
    go(1'b0, 1'b1);
    cyc(3);
    `CHK(slow_f, 1'b0)
    set(0, 1'b1);
    cyc(6);
    `CHK(nv_d, 4'h1)
    nq.push_back(4'h0);
    set(0, 1'b0);
    cyc(6);
    `CHK(nv_d, 4'h0)
    set(4, 1'b1);
    go(1'b1, 1'b0);
    nq.push_back(4'h1);
    set(0, 1'b1);
    cyc(6);
    `CHK(slow_f, 1'b0)
    set(4, 1'b0);
    cyc(6);
    `CHK(slow_f, 1'b1)
    // distance stop: rated speed is still zero, so it runs until cancelled
    bus(1'b1, 5'h00, 32'h0000_0127);
    set(0, 1'b0);
    cyc(4);
    set(0, 1'b1);
    cyc(6);
    `CHK(sad, 1'b1)
    go(1'b0, 1'b1);
    cyc(3);
    `CHK(sad, 1'b0)
    bus(1'b1, 5'h00, 32'h0000_0025);
    go(1'b0, 1'b0);
    set(3, 1'b1);
    cyc(6);
    go(1'b0, 1'b1);
    nq.push_back(4'h9);
    set(3, 1'b0);
    cyc(6);
    `CHK(stop, 1'b1)
    @(posedge clk_in);
    rst_in <= 1'b1;
    cyc(3);
    rst_in <= 1'b0;
    cyc(4);
    `CHK(nv_d, 4'h9)
    // factory restore with long cams: clear, then take the levels as they stand
    nq.push_back(4'h0);
    nq.push_back(4'h8);
    bus(1'b1, 5'h00, 32'h0000_0C25);
    cyc(4);
    `CHK(nv_d, 4'h8)
    `CHK(nq.size(), 0)
    end_of_test();
  end
endmodule
`default_nettype wire
